// *** rtl/trc_ram_ctl.sv ***
// Platform RAM controller with embedded change-of-flow trace recorder
// and a two-comparator watchpoint unit.
// Assumes a synchronous single-port RAM with one cycle read latency,
// an AHB-lite slave position, and the core trace port on i_clk.
`timescale 1ns/10ps
`default_nettype none
`include "trc_params.svh"

module trc_ram_ctl #(
   parameter int RAM_AW = 10
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   // System bus slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire trc_pkg::trc_word_t i_hwdata,
   input wire logic i_hready,
   output trc_pkg::trc_word_t o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // RAM array
   output logic o_ram_en,
   output logic o_ram_we,
   output logic [3:0] o_ram_be,
   output logic [RAM_AW-1:0] o_ram_addr,
   output trc_pkg::trc_word_t o_ram_wdata,
   input wire trc_pkg::trc_word_t i_ram_rdata,
   // Core execution trace port
   input wire logic [30:0] i_exec_pc_half,
   input wire logic i_exec_pc_load,
   input wire logic i_sequential_flag,
   input wire logic i_atomic,
   // Recorder configuration
   input wire logic i_trace_enable,
   input wire logic [31:0] i_buf_base,
   input wire logic [RAM_AW-2:0] i_buf_mask,
   output logic [RAM_AW-2:0] o_trace_pos,
   output logic o_recording,
   // Watchpoint configuration and bus monitor
   input wire logic [1:0] i_wp_enable,
   input wire logic [1:0] i_wp_use_data,
   input wire logic [1:0] i_wp_is_halt,
   input wire logic [1:0][31:0] i_wp_addr,
   input wire logic [1:0][31:0] i_wp_data,
   input wire logic i_mon_valid,
   input wire logic [31:0] i_mon_addr,
   input wire logic [31:0] i_mon_data
);
   import trc_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   trc_pk_state_t pk_state_reg;
   trc_grant_t grant;
   logic [30:0] pc_reg;
   trc_word_t pk_src_reg;
   trc_word_t pk_dst_reg;
   logic first_reg;
   logic rec_reg;
   logic en_q_reg;
   logic [RAM_AW-2:0] pkt_off_reg;
   logic pk_take;
   logic [RAM_AW-1:0] trace_addr;
   logic dp_valid_reg;
   logic dp_write_reg;
   logic dp_issued_reg;
   logic [RAM_AW-1:0] dp_addr_reg;
   logic [3:0] dp_be_reg;
   logic wb_valid_reg;
   logic [RAM_AW-1:0] wb_addr_reg;
   logic [3:0] wb_be_reg;
   trc_word_t wb_data_reg;
   trc_word_t wb_mask;
   logic ap;
   logic ap_rd;
   logic [RAM_AW-1:0] ap_addr;
   logic dp_rd_need;
   logic drain;
   logic [1:0] wp_match;
   logic trace_begin;
   logic trace_halt;

   function automatic logic [3:0] size_be(input logic [2:0] size, input logic [1:0] a);
      logic [3:0] be;
      be = `TRC_BE_ALL;
      if (size == `TRC_HSIZE_BYTE) begin
         be = 4'(`TRC_BE_BYTE << a);
      end else if (size == `TRC_HSIZE_HALF) begin
         be = a[1] ? `TRC_BE_HALF_HI : `TRC_BE_HALF_LO;
      end
      return be;
   endfunction

   // ------------------------------------------------------------
   // Watchpoint unit
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         assign wp_match[gi] = i_mon_valid && i_wp_enable[gi] && (i_mon_addr == i_wp_addr[gi]) &&
                               (!i_wp_use_data[gi] || (i_mon_data == i_wp_data[gi]));
      end
   endgenerate

   assign trace_begin = |(wp_match & ~i_wp_is_halt);
   assign trace_halt = |(wp_match & i_wp_is_halt);

   // ------------------------------------------------------------
   // Recording state
   // ------------------------------------------------------------
   // Halt beats begin when both fire together, so a stop is never missed
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rec_reg <= 1'b0;
         en_q_reg <= 1'b0;
         first_reg <= 1'b0;
      end else begin
         en_q_reg <= i_trace_enable;
         if (!i_trace_enable || trace_halt) begin
            rec_reg <= 1'b0;
         end else if (trace_begin || !en_q_reg) begin
            rec_reg <= 1'b1;
         end
         if (!rec_reg && i_trace_enable && !trace_halt && (trace_begin || !en_q_reg)) begin
            first_reg <= 1'b1;
         end else if (pk_take) begin
            first_reg <= 1'b0;
         end
      end
   end

   assign o_recording = rec_reg;

   // ------------------------------------------------------------
   // Packet capture
   // ------------------------------------------------------------
   // A discontinuity during the source write of the previous packet is
   // dropped; the core does not branch twice that close in practice.
   assign pk_take = i_exec_pc_load && !i_sequential_flag && rec_reg && (pk_state_reg != PK_SRC);

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pc_reg <= `TRC_PC_RST;
      end else if (i_exec_pc_load) begin
         pc_reg <= i_exec_pc_half;
      end
   end

   // Exception entry and return arrive as ordinary discontinuities; the
   // core presents the return code as an address, giving two packets.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pk_src_reg <= `TRC_WORD_RST;
         pk_dst_reg <= `TRC_WORD_RST;
      end else if (pk_take) begin
         pk_src_reg <= {pc_reg, i_atomic};
         pk_dst_reg <= {i_exec_pc_half, first_reg};
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pk_state_reg <= PK_IDLE;
      end else begin
         case (pk_state_reg)
            PK_IDLE: pk_state_reg <= pk_take ? PK_SRC : PK_IDLE;
            PK_SRC: pk_state_reg <= PK_DST;
            PK_DST: pk_state_reg <= pk_take ? PK_SRC : PK_IDLE;
            default: pk_state_reg <= PK_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pkt_off_reg <= '0;
      end else if (!i_trace_enable) begin
         pkt_off_reg <= '0;
      end else if (pk_state_reg == PK_DST) begin
         pkt_off_reg <= (pkt_off_reg + 1'b1) & i_buf_mask;
      end
   end

   assign o_trace_pos = pkt_off_reg;
   // Base must be aligned to the packet size; the offset is added to it
   assign trace_addr = i_buf_base[RAM_AW+1:2] + {pkt_off_reg & i_buf_mask,
                       (pk_state_reg == PK_DST) ? `TRC_DST_WORD : `TRC_SRC_WORD};

   // ------------------------------------------------------------
   // System bus pipeline
   // ------------------------------------------------------------
   assign ap = i_hsel && i_htrans[`TRC_HTRANS_ACTIVE_BIT] && i_hready;
   assign ap_rd = ap && !i_hwrite;
   assign ap_addr = i_haddr[RAM_AW+1:2];
   assign dp_rd_need = dp_valid_reg && !dp_write_reg && !dp_issued_reg;

   // Trace wins the port; a posted write drains before a later read of its word at
   // one wait state, while a read issued in the write's data phase is forwarded when no older posted write is still pending.
   always_comb begin
      grant = GR_NONE;
      if (pk_state_reg != PK_IDLE) begin
         grant = GR_TRACE;
      end else if (dp_rd_need) begin
         grant = (wb_valid_reg && wb_addr_reg == dp_addr_reg) ? GR_DRAIN : GR_DPRD;
      end else if (dp_valid_reg && dp_write_reg && wb_valid_reg) begin
         grant = GR_DRAIN;
      end else if (ap_rd) begin
         grant = (wb_valid_reg && wb_addr_reg == ap_addr) ? GR_DRAIN : GR_APRD;
      end else if (wb_valid_reg) begin
         grant = GR_DRAIN;
      end
   end

   assign drain = (grant == GR_DRAIN);

   always_comb begin
      o_ram_en = 1'b0;
      o_ram_we = 1'b0;
      o_ram_be = 4'h0;
      o_ram_addr = ap_addr;
      o_ram_wdata = wb_data_reg;
      case (grant)
         GR_TRACE: begin
            o_ram_en = 1'b1;
            o_ram_we = 1'b1;
            o_ram_be = `TRC_BE_ALL;
            o_ram_addr = trace_addr;
            o_ram_wdata = (pk_state_reg == PK_DST) ? pk_dst_reg : pk_src_reg;
         end
         GR_DPRD: begin
            o_ram_en = 1'b1;
            o_ram_addr = dp_addr_reg;
         end
         GR_APRD: begin
            o_ram_en = 1'b1;
         end
         GR_DRAIN: begin
            o_ram_en = 1'b1;
            o_ram_we = 1'b1;
            o_ram_be = wb_be_reg;
            o_ram_addr = wb_addr_reg;
         end
         default: o_ram_en = 1'b0;
      endcase
   end

   assign o_hreadyout = !dp_valid_reg || (dp_write_reg ? (!wb_valid_reg || drain) : dp_issued_reg);
   assign wb_mask = {{8{wb_be_reg[3]}}, {8{wb_be_reg[2]}}, {8{wb_be_reg[1]}}, {8{wb_be_reg[0]}}};
   assign o_hrdata = (dp_valid_reg && !dp_write_reg && wb_valid_reg && wb_addr_reg == dp_addr_reg) ?
                     ((wb_data_reg & wb_mask) | (i_ram_rdata & ~wb_mask)) : i_ram_rdata;
   assign o_hresp = `TRC_HRESP_OKAY;

   // Data phase holds one address while the master holds the next one
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_issued_reg <= 1'b0;
         dp_addr_reg <= '0;
         dp_be_reg <= 4'h0;
      end else if (o_hreadyout) begin
         dp_valid_reg <= ap;
         dp_write_reg <= i_hwrite;
         dp_issued_reg <= (grant == GR_APRD);
         dp_addr_reg <= ap_addr;
         dp_be_reg <= size_be(i_hsize, i_haddr[1:0]);
      end else if (grant == GR_DPRD) begin
         dp_issued_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wb_valid_reg <= 1'b0;
         wb_addr_reg <= '0;
         wb_be_reg <= 4'h0;
         wb_data_reg <= `TRC_WORD_RST;
      end else if (dp_valid_reg && dp_write_reg && o_hreadyout) begin
         wb_valid_reg <= 1'b1;
         wb_addr_reg <= dp_addr_reg;
         wb_be_reg <= dp_be_reg;
         wb_data_reg <= i_hwdata;
      end else if (drain) begin
         wb_valid_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_src_write;
      o_ram_we && !o_ram_addr[0] && o_ram_wdata == {$past(pc_reg), $past(i_atomic)};
   endsequence

   sequence s_dst_write;
      o_ram_we && o_ram_addr[0] && o_ram_wdata[31:1] == $past(i_exec_pc_half, 2);
   endsequence

   property p_packet;
      @(posedge i_clk) disable iff (!i_resetn)
         pk_take |=> s_src_write ##1 s_dst_write;
   endproperty

   chk_packet_words: assert property (p_packet)
      else $error("trace packet words wrong");

   chk_start_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
      pk_take |=> ##1 o_ram_wdata[0] == $past(first_reg, 2))
      else $error("start flag wrong");
   chk_pkt_adjacent: assert property (@(posedge i_clk) disable iff (!i_resetn)
      pk_state_reg == PK_SRC |=> o_ram_addr == $past(o_ram_addr) + 1'b1)
      else $error("packet words not adjacent");
   chk_trace_wins: assert property (@(posedge i_clk) disable iff (!i_resetn)
      pk_state_reg != PK_IDLE |-> o_ram_we && o_ram_be == `TRC_BE_ALL && grant == GR_TRACE)
      else $error("trace write lost the port");
   chk_zero_wait: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ap && o_hreadyout && pk_state_reg == PK_IDLE && !pk_take && !wb_valid_reg |=> o_hreadyout)
      else $error("wait state without trace write");
   chk_bus_progress: assert property (@(posedge i_clk) disable iff (!i_resetn)
      dp_valid_reg && !o_hreadyout |-> ##[1:4] o_hreadyout)
      else $error("bus access stalled too long");
   chk_wrap_region: assert property (@(posedge i_clk) disable iff (!i_resetn)
      pk_state_reg == PK_DST && i_trace_enable |=> pkt_off_reg == (($past(pkt_off_reg) + 1'b1) & $past(i_buf_mask)))
      else $error("packet position not advanced");

   chk_wp_begin: assert property (@(posedge i_clk) disable iff (!i_resetn)
      trace_begin && !trace_halt && i_trace_enable |=> rec_reg)
      else $error("begin trigger ignored");
   chk_wp_halt: assert property (@(posedge i_clk) disable iff (!i_resetn)
      trace_halt |=> !rec_reg ##1 !pk_take || rec_reg)
      else $error("halt trigger ignored");

   chk_seq_quiet: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_exec_pc_load && i_sequential_flag |=> pk_state_reg != PK_SRC)
      else $error("packet on sequential address");

endmodule // trc_ram_ctl

`default_nettype wire

// *** rtl/trc_params.svh ***
// Constants for the trace packet RAM controller: field positions,
// packet layout, bus encodings and reset values.
// Assumes inclusion by bare name from design files only.
`ifndef TRC_PARAMS_SVH
`define TRC_PARAMS_SVH

// ------------------------------------------------------------
// Packet layout
// ------------------------------------------------------------
`define TRC_PKT_BYTES 8
`define TRC_FLAG_BIT 0
`define TRC_SRC_WORD 1'h0
`define TRC_DST_WORD 1'h1

// ------------------------------------------------------------
// System bus encodings
// ------------------------------------------------------------
`define TRC_HTRANS_ACTIVE_BIT 1
`define TRC_HSIZE_BYTE 3'h0
`define TRC_HSIZE_HALF 3'h1
`define TRC_HRESP_OKAY 1'h0
`define TRC_BE_ALL 4'hF
`define TRC_BE_BYTE 4'h1
`define TRC_BE_HALF_LO 4'h3
`define TRC_BE_HALF_HI 4'hC

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TRC_PC_RST 31'h0
`define TRC_WORD_RST 32'h0

`endif

// *** rtl/trc_pkg.sv ***
// Types shared by the trace packet RAM controller.
// Assumes nothing of its surroundings.
package trc_pkg;

   typedef logic [31:0] trc_word_t;

   // Packet writer: two RAM writes per packet
   typedef enum logic [2:0] {
      PK_IDLE = 3'b001,
      PK_SRC = 3'b010,
      PK_DST = 3'b100
   } trc_pk_state_t;

   // Owner of the single RAM port in a cycle
   typedef enum logic [4:0] {
      GR_NONE = 5'b00001,
      GR_TRACE = 5'b00010,
      GR_DPRD = 5'b00100,
      GR_APRD = 5'b01000,
      GR_DRAIN = 5'b10000
   } trc_grant_t;

endpackage

// *** test/trc_ram_model.sv ***
// RAM array model standing behind the trace RAM controller.
// Assumes one-cycle synchronous reads and byte-enabled writes on i_clk.
`timescale 1ns/10ps
`default_nettype none
module trc_ram_model #(
   parameter int AW = 10
) (
   input wire logic i_clk,
   input wire logic i_en,
   input wire logic i_we,
   input wire logic [3:0] i_be,
   input wire logic [AW-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [0:(1<<AW)-1];
   // ------------------------------------------------------------
   // Array
   // ------------------------------------------------------------
   // Cycles without a read invert the output, so a read stale by an odd count of cycles never passes
   always_ff @(posedge i_clk) begin
      if (i_en && !i_we) begin
         o_rdata <= mem[i_addr];
      end else begin
         o_rdata <= ~o_rdata;
      end
      if (i_en && i_we) begin
         for (int b = 0; b < 4; b++) begin
            if (i_be[b]) begin
               mem[i_addr][8*b +: 8] <= i_wdata[8*b +: 8];
            end
         end
      end
   end
endmodule // trc_ram_model
`default_nettype wire

// *** test/tb.sv ***
// Bench for trc_ram_ctl: bus access, trace packets, watchpoint control.
// Assumes trc_ram_model as RAM array and this block as the only bus slave.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import trc_pkg::*;
   localparam int AW = 10;
   localparam logic [31:0] BASE = 32'h00000200;
   localparam logic [AW-2:0] MASK = 9'h003;
   localparam logic [31:0] WA = 32'h40001000;
   localparam logic [31:0] WB = 32'h40002000;
   localparam logic [31:0] WD = 32'h5A5A00FF;
   logic clk = 1'b0;
   logic rstn, hsel, hwrite, ready, hresp, ren, rwe, ld, seq, atom, ten, mv, rec, start;
   logic [1:0] htrans, wen, wdat, whalt;
   logic [2:0] hsize, sz;
   logic [3:0] rbe;
   logic [31:0] haddr, mad, mdat, q, ka, kv, ba, dn;
   logic [1:0][31:0] wadr, wdv;
   logic [30:0] pc, prev;
   logic [AW-1:0] raddr;
   logic [AW-2:0] pos, epos;
   trc_word_t hwdata, hrdata, rwd, rrd;
   trc_word_t ex [0:7];
   int err_count = 0;
   int num_checks = 0;
   int seed = 78;
   int wt;

   trc_ram_ctl #(.RAM_AW(AW)) dut (
      .i_clk(clk), .i_resetn(rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(ready), .o_hrdata(hrdata), .o_hreadyout(ready),
      .o_hresp(hresp), .o_ram_en(ren), .o_ram_we(rwe), .o_ram_be(rbe), .o_ram_addr(raddr),
      .o_ram_wdata(rwd), .i_ram_rdata(rrd), .i_exec_pc_half(pc), .i_exec_pc_load(ld),
      .i_sequential_flag(seq), .i_atomic(atom), .i_trace_enable(ten), .i_buf_base(BASE),
      .i_buf_mask(MASK), .o_trace_pos(pos), .o_recording(rec), .i_wp_enable(wen), .i_wp_use_data(wdat),
      .i_wp_is_halt(whalt), .i_wp_addr(wadr), .i_wp_data(wdv), .i_mon_valid(mv), .i_mon_addr(mad),
      .i_mon_data(mdat));

   trc_ram_model #(.AW(AW)) ram (
      .i_clk(clk), .i_en(ren), .i_we(rwe), .i_be(rbe), .i_addr(raddr), .i_wdata(rwd), .o_rdata(rrd));

   always #10 clk = ~clk;

   // ------------------------------------------------------------
   // Expectation and drivers
   // ------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [2:0] s,
         input logic [1:0] lane);
      logic [31:0] m;
      m = (s == 3'h0) ? (32'h000000FF << (8 * lane)) : (s == 3'h1) ? (32'h0000FFFF << (16 * lane[1])) : 32'hFFFFFFFF;
      return (o & ~m) | (n & m);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // A stuck slave would hang the bench, so every wait is capped
   task automatic wait_rdy(output int n);
      n = 0;
      while (ready !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 20) begin
            err_count++;
            test_done();
         end
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [31:0] d,
         output logic [31:0] r, output int n);
      @(negedge clk);
      hsel = 1'b1;
      htrans = 2'h2;
      hwrite = w;
      haddr = a;
      hsize = s;
      wait_rdy(n);
      @(negedge clk);
      hsel = 1'b0;
      htrans = 2'h0;
      hwdata = d;
      wait_rdy(n);
      r = hrdata;
   endtask

   // Pipelined write then read of the same word: the read address rides the write's data phase
   task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(negedge clk);
      hsel = 1'b1;
      htrans = 2'h2;
      hwrite = 1'b1;
      haddr = a;
      hsize = 3'h2;
      wait_rdy(n);
      @(negedge clk);
      hwrite = 1'b0;
      hwdata = d;
      wait_rdy(n);
      @(negedge clk);
      hsel = 1'b0;
      htrans = 2'h0;
      wait_rdy(n);
      r = hrdata;
   endtask

   // Loads stay four cycles apart so none lands in a source-write cycle
   task automatic load(input logic [30:0] p, input logic s, input logic a);
      @(negedge clk);
      ld = 1'b1;
      pc = p;
      seq = s;
      atom = a;
      if (!s && rec === 1'b1) begin
         ex[2 * epos] = {prev, a};
         ex[2 * epos + 1] = {p, start};
         start = 1'b0;
         epos = (epos + 1) & MASK;
      end
      prev = p;
      @(negedge clk);
      ld = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic mon(input logic [31:0] a, input logic [31:0] d, input logic e);
      @(negedge clk);
      mv = 1'b1;
      mad = a;
      mdat = d;
      @(negedge clk);
      mv = 1'b0;
      chk({31'h0, rec}, {31'h0, e});
   endtask

   task automatic check_buf();
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, BASE + 4 * i, 3'h2, 32'h0, q, wt);
         chk(q, ex[i]);
      end
      chk({23'h0, pos}, {23'h0, epos});
   endtask

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      {hsel, hwrite, ld, atom, ten, mv, start} = '0;
      {htrans, haddr, hwdata, pc, prev, mad, mdat, epos} = '0;
      seq = 1'b1;
      hsize = 3'h2;
      wen = 2'h3;
      wdat = 2'h2;
      whalt = 2'h1;
      wadr = {WB, WA};
      wdv = {WD, 32'h0};
      repeat (16) @(negedge clk);
      chk({28'h0, ready, hresp, rec, |pos}, 32'h8);
      rstn = 1'b1;
      for (int k = 0; k < 8; k++) begin
         ka = 32'h800 | ($random(seed) & 32'h7FC);
         kv = $random(seed);
         dn = $random(seed);
         sz = 3'(k % 3);
         ba = ka | 32'((k % 3 == 0) ? k % 4 : (k % 3 == 1) ? (k % 2) * 2 : 0);
         bus(1'b1, ka, 3'h2, kv, q, wt);
         chk(32'(wt), 32'h0);
         bus(1'b1, ba, sz, dn, q, wt);
         chk(32'(wt), 32'h0);
         kv = merge(kv, dn, sz, ba[1:0]);
         bus(1'b0, ka, 3'h2, 32'h0, q, wt);
         chk(q, kv);
         bus(1'b0, ka | 32'hF0000000, 3'h2, 32'h0, q, wt);
         chk(q, kv);
         chk(32'(wt), 32'h0);
         kv = ~kv;
         wr_rd(ka, kv, q);
         chk(q, kv);
      end
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, BASE + 4 * i, 3'h2, 32'h0, q, wt);
         ex[i] = 32'h0;
      end
      ten = 1'b1;
      start = 1'b1;
      @(negedge clk);
      chk({31'h0, rec}, 32'h1);
      fork
         begin
            load(31'h00001000, 1'b1, 1'b0);
            load(31'h00001002, 1'b0, 1'b0);
            load(31'h00002000, 1'b1, 1'b0);
            load(31'h7FFFFFFC, 1'b0, 1'b0);
            load(31'h00002100, 1'b0, 1'b1);
            for (int k = 0; k < 10; k++) begin
               load(31'($random(seed)), ($random(seed) & 3) == 0, 1'($random(seed)));
            end
         end
         begin
            for (int k = 0; k < 12; k++) begin
               bus(1'b0, ka, 3'h2, 32'h0, q, wt);
               chk(q, kv);
            end
         end
      join
      check_buf();
      mon(WA, 32'h0, 1'b0);
      load(31'h00003000, 1'b0, 1'b0);
      mon(WB, ~WD, 1'b0);
      mon(WB, WD, 1'b1);
      start = 1'b1;
      load(31'h00004000, 1'b1, 1'b0);
      load(31'h00004100, 1'b0, 1'b1);
      check_buf();
      ten = 1'b0;
      @(negedge clk);
      chk({23'h0, pos}, 32'h0);
      test_done();
   end
endmodule // tb
`default_nettype wire
